/* cyclic_timer_pkg.sv */
`default_nettype none
// shared constants for the dual cyclic sense timer
package cyclic_timer_pkg;

  // register port widths
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;

  // register word addresses on the 7-bit map
  localparam logic [6:0] TMR_A_ADDR = 7'h0C;
  localparam logic [6:0] TMR_B_ADDR = 7'h0D;

  // reset value of both control registers
  localparam logic [7:0] TMR_RST_VAL = 8'h00;

  // field positions inside a control register
  localparam int ON_MSB = 6;
  localparam int ON_LSB = 4;
  localparam int PER_MSB = 2;
  localparam int PER_LSB = 0;

  // on-time and period codes with a special meaning
  localparam logic [2:0] ON_STOP_LOW = 3'h0;
  localparam logic [2:0] ON_STOP_HIGH = 3'h6;
  localparam logic [2:0] ON_RSVD = 3'h7;
  localparam logic [2:0] PER_RSVD = 3'h7;

  // clock rate and the base tick of the period counters
  localparam int CLK_MHZ = 200;
  localparam int TICK_US = 1;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;

  // on-times in microseconds
  localparam int ON_0P1MS_US = 100;
  localparam int ON_0P3MS_US = 300;
  localparam int ON_1MS_US = 1000;
  localparam int ON_10MS_US = 10000;
  localparam int ON_20MS_US = 20000;

  // periods in microseconds
  localparam int PER_10MS_US = 10000;
  localparam int PER_20MS_US = 20000;
  localparam int PER_50MS_US = 50000;
  localparam int PER_100MS_US = 100000;
  localparam int PER_200MS_US = 200000;
  localparam int PER_1S_US = 1000000;
  localparam int PER_2S_US = 2000000;

  // wake filter window at the end of the on-time, least time rounds up
  localparam int FILT_US = 16;
  localparam int FILT_TICKS = (FILT_US + TICK_US - 1) / TICK_US;

  // tick counter width: holds the 2 s period in ticks
  localparam int CNT_W = 21;

  // timer states, gray along off-low, run, off-high
  typedef enum logic [1:0] {
    ST_OFF_LOW  = 2'h0,
    ST_RUN      = 2'h1,
    ST_OFF_HIGH = 2'h3
  } tmr_state_t;

  typedef logic [CNT_W-1:0] tick_cnt_t;

endpackage
`default_nettype wire

/* dual_cyclic_sense_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - on-time bits 6:4; 000 stops, output low
// - codes 001-101 give 0.1 to 20 ms
// - on-time 110 stops timer, output high
// - period bits 2:0; 10 ms to 2 s
// - bits 7 and 3 always read zero
// - both registers zero after every reset kind
// - assigned timer starts when on-time written
// - restart switch clear also clears timer fields, only with cyclic sense in use
// - wake and sensing run together from timer
// - timer a register at address 0001100
// - timer b at 0001101, same layout
// - 16 us filter window ends on-time
module dual_cyclic_sense_timer #(
  // clock cycles per counter tick; shrink to speed up simulation
  parameter int TICK_CYC = cyclic_timer_pkg::TICK_CYC
) (
  input wire logic CLK_I,
  input wire logic NRST_I,
  // synchronous soft reset and restart entry pulses
  input wire logic SOFT_RST_I,
  input wire logic RESTART_I,
  // restart-mode clear of the switch settings, with cyclic sense in use
  input wire logic RESTART_HS_CLR_I,
  input wire logic CYCLIC_SENSE_I,
  // register port
  input wire logic [6:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  // a switch has been assigned to the timer
  input wire logic TMR_A_ASSIGNED_I,
  input wire logic TMR_B_ASSIGNED_I,
  // timer enabled as wake source
  input wire logic TMR_A_WAKE_EN_I,
  input wire logic TMR_B_WAKE_EN_I,
  // drive level for the switch outputs assigned to each timer
  output logic TMR_A_OUT_O,
  output logic TMR_B_OUT_O,
  // wake filter sampling window at the end of the on-time
  output logic TMR_A_FILT_O,
  output logic TMR_B_FILT_O,
  // cyclic wake window, active beside cyclic sensing
  output logic TMR_A_WAKE_O,
  output logic TMR_B_WAKE_O
);

  // on-time code to length in ticks; zero for the stop codes
  // the reserved code 111 also maps to zero
  function automatic cyclic_timer_pkg::tick_cnt_t on_ticks(
    input logic [2:0] code
  );
    cyclic_timer_pkg::tick_cnt_t len;
    len = '0;
    case (code)
      3'h1: len = cyclic_timer_pkg::tick_cnt_t'(
                cyclic_timer_pkg::ON_0P1MS_US / cyclic_timer_pkg::TICK_US);
      3'h2: len = cyclic_timer_pkg::tick_cnt_t'(
                cyclic_timer_pkg::ON_0P3MS_US / cyclic_timer_pkg::TICK_US);
      3'h3: len = cyclic_timer_pkg::tick_cnt_t'(
                cyclic_timer_pkg::ON_1MS_US / cyclic_timer_pkg::TICK_US);
      3'h4: len = cyclic_timer_pkg::tick_cnt_t'(
                cyclic_timer_pkg::ON_10MS_US / cyclic_timer_pkg::TICK_US);
      3'h5: len = cyclic_timer_pkg::tick_cnt_t'(
                cyclic_timer_pkg::ON_20MS_US / cyclic_timer_pkg::TICK_US);
      default: len = '0; // stop and reserved codes
    endcase
    return len;
  endfunction

  // period code to length in ticks; zero for the reserved code
  function automatic cyclic_timer_pkg::tick_cnt_t per_ticks(
    input logic [2:0] code
  );
    cyclic_timer_pkg::tick_cnt_t len;
    len = '0;
    case (code)
      3'h0: len = cyclic_timer_pkg::tick_cnt_t'(
                cyclic_timer_pkg::PER_10MS_US / cyclic_timer_pkg::TICK_US);
      3'h1: len = cyclic_timer_pkg::tick_cnt_t'(
                cyclic_timer_pkg::PER_20MS_US / cyclic_timer_pkg::TICK_US);
      3'h2: len = cyclic_timer_pkg::tick_cnt_t'(
                cyclic_timer_pkg::PER_50MS_US / cyclic_timer_pkg::TICK_US);
      3'h3: len = cyclic_timer_pkg::tick_cnt_t'(
                cyclic_timer_pkg::PER_100MS_US / cyclic_timer_pkg::TICK_US);
      3'h4: len = cyclic_timer_pkg::tick_cnt_t'(
                cyclic_timer_pkg::PER_200MS_US / cyclic_timer_pkg::TICK_US);
      3'h5: len = cyclic_timer_pkg::tick_cnt_t'(
                cyclic_timer_pkg::PER_1S_US / cyclic_timer_pkg::TICK_US);
      3'h6: len = cyclic_timer_pkg::tick_cnt_t'(
                cyclic_timer_pkg::PER_2S_US / cyclic_timer_pkg::TICK_US);
      default: len = '0; // reserved period keeps the timer stopped
    endcase
    return len;
  endfunction

  // every on-time and period is counted in ticks of the prescaler;
  // 16 bits hold TICK_CYC - 1 for any rate this block is built for
  localparam int TICK_W = 16;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);
  localparam cyclic_timer_pkg::tick_cnt_t FILT_LEN =
    cyclic_timer_pkg::tick_cnt_t'(cyclic_timer_pkg::FILT_TICKS);

  // shared tick prescaler
  // one prescaler for both timers saves a counter per timer
  logic [TICK_W-1:0] pre_r; // cycles within the current tick
  logic [TICK_W-1:0] pre_nxt;
  logic tick_r; // one-cycle tick enable
  logic tick_nxt;

  // per-timer control fields, index 0 is timer a
  logic [2:0] on_r [2]; // on-time code
  logic [2:0] on_nxt [2];
  logic [2:0] per_r [2]; // period code
  logic [2:0] per_nxt [2];

  // per-timer running state
  // the count spans a whole period, on-time and off-time alike
  cyclic_timer_pkg::tmr_state_t st_r [2];
  cyclic_timer_pkg::tmr_state_t st_nxt [2];
  cyclic_timer_pkg::tick_cnt_t cnt_r [2]; // ticks since period start
  cyclic_timer_pkg::tick_cnt_t cnt_nxt [2];

  // registered outputs per timer
  logic out_r [2];
  logic out_nxt [2];
  logic filt_r [2];
  logic filt_nxt [2];
  logic wake_r [2];
  logic wake_nxt [2];

  // read data, valid only in the cycle after a read strobe
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  // port bundles into per-timer arrays
  // indexing by timer keeps a single copy of the timer logic
  logic assigned [2];
  logic wake_en [2];
  logic [6:0] reg_addr [2];

  assign assigned[0] = TMR_A_ASSIGNED_I;
  assign assigned[1] = TMR_B_ASSIGNED_I;
  assign wake_en[0] = TMR_A_WAKE_EN_I;
  assign wake_en[1] = TMR_B_WAKE_EN_I;
  assign reg_addr[0] = cyclic_timer_pkg::TMR_A_ADDR;
  assign reg_addr[1] = cyclic_timer_pkg::TMR_B_ADDR;

  // any of the reset kinds that bring the fields back to zero
  // a clear is a plain synchronous pulse from the mode logic
  logic clr_all;
  assign clr_all = SOFT_RST_I | RESTART_I |
                   (RESTART_HS_CLR_I & CYCLIC_SENSE_I);

  // prescaler: free-running, so a rewrite may see up to one tick of
  // jitter before its first count; cheaper than a prescaler per timer
  always_comb begin
    pre_nxt = pre_r + 16'h0001;
    tick_nxt = 1'b0;
    if (pre_r >= TICK_LAST) begin
      pre_nxt = 16'h0000;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      // count restarts from zero so the tick phase is known after reset
      pre_r <= 16'h0000;
      tick_r <= 1'b0;
    end else begin
      pre_r <= pre_nxt;
      tick_r <= tick_nxt;
    end
  end

  // control registers: writes and the clearing resets
  // bits 7 and 3 have no flip-flops, so reads fill them with zero
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      on_nxt[i] = on_r[i];
      per_nxt[i] = per_r[i];
      if (clr_all) begin
        // clear wins over a write in the same cycle
        on_nxt[i] = cyclic_timer_pkg::TMR_RST_VAL[6:4];
        per_nxt[i] = cyclic_timer_pkg::TMR_RST_VAL[2:0];
      end else if (WR_I && ADDR_I == reg_addr[i]) begin
        // bits 7 and 3 have no storage
        on_nxt[i] = WDATA_I[cyclic_timer_pkg::ON_MSB:
                            cyclic_timer_pkg::ON_LSB];
        per_nxt[i] = WDATA_I[cyclic_timer_pkg::PER_MSB:
                             cyclic_timer_pkg::PER_LSB];
      end
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      for (int i = 0; i < 2; i++) begin
        // both fields come up at the all-zero reset value
        on_r[i] <= 3'h0;
        per_r[i] <= 3'h0;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        on_r[i] <= on_nxt[i];
        per_r[i] <= per_nxt[i];
      end
    end
  end

  // timer state, period counter and output windows
  always_comb begin
    cyclic_timer_pkg::tick_cnt_t on_len;
    cyclic_timer_pkg::tick_cnt_t per_len;
    logic restart;
    on_len = '0;
    per_len = '0;
    restart = 1'b0;
    for (int i = 0; i < 2; i++) begin
      // lengths follow the value being written, so the write edge counts
      on_len = on_ticks(on_nxt[i]);
      per_len = per_ticks(per_nxt[i]);
      // rewriting a field restarts the period from its start
      restart = WR_I && ADDR_I == reg_addr[i];
      // state comes from the next fields, not the stored ones
      case (on_nxt[i])
        cyclic_timer_pkg::ON_STOP_LOW: begin
          st_nxt[i] = cyclic_timer_pkg::ST_OFF_LOW;
        end
        cyclic_timer_pkg::ON_STOP_HIGH: begin
          st_nxt[i] = cyclic_timer_pkg::ST_OFF_HIGH;
        end
        cyclic_timer_pkg::ON_RSVD: begin
          // reserved on-time behaves as stopped low
          st_nxt[i] = cyclic_timer_pkg::ST_OFF_LOW;
        end
        default: begin
          // runs by itself once assigned; no start command exists
          if (assigned[i] && per_nxt[i] != cyclic_timer_pkg::PER_RSVD) begin
            st_nxt[i] = cyclic_timer_pkg::ST_RUN;
          end else begin
            st_nxt[i] = cyclic_timer_pkg::ST_OFF_LOW;
          end
        end
      endcase
      // count ticks while running, wrap at the period end
      // a fresh start or a rewrite holds the count at zero for a cycle
      if (st_nxt[i] != cyclic_timer_pkg::ST_RUN || restart ||
          st_r[i] != cyclic_timer_pkg::ST_RUN) begin
        cnt_nxt[i] = '0;
      end else if (tick_r) begin
        if (cnt_r[i] >= per_len - 21'h000001) begin
          cnt_nxt[i] = '0;
        end else begin
          cnt_nxt[i] = cnt_r[i] + 21'h000001;
        end
      end else begin
        cnt_nxt[i] = cnt_r[i];
      end
      // output windows follow the next state and count
      case (st_nxt[i])
        cyclic_timer_pkg::ST_RUN: begin
          out_nxt[i] = cnt_nxt[i] < on_len;
          // last 16 us of the on-time samples the wake filter
          filt_nxt[i] = cnt_nxt[i] < on_len &&
                        cnt_nxt[i] + FILT_LEN >= on_len;
        end
        cyclic_timer_pkg::ST_OFF_HIGH: begin
          out_nxt[i] = 1'b1;
          filt_nxt[i] = 1'b0;
        end
        default: begin
          out_nxt[i] = 1'b0;
          filt_nxt[i] = 1'b0;
        end
      endcase
      // at the end of the on-time the filter and output fall together
      // wake shares the sensing window rather than replacing it
      wake_nxt[i] = wake_en[i] && filt_nxt[i];
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      for (int i = 0; i < 2; i++) begin
        // both timers stopped low with the count at zero
        st_r[i] <= cyclic_timer_pkg::ST_OFF_LOW;
        cnt_r[i] <= '0;
        out_r[i] <= 1'b0;
        filt_r[i] <= 1'b0;
        wake_r[i] <= 1'b0;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        st_r[i] <= st_nxt[i];
        cnt_r[i] <= cnt_nxt[i];
        out_r[i] <= out_nxt[i];
        filt_r[i] <= filt_nxt[i];
        wake_r[i] <= wake_nxt[i];
      end
    end
  end

  // read path: unused bits and unmapped addresses read zero
  // the strobe gates the data, so a stale value never stands idle
  always_comb begin
    rdata_nxt = 8'h00;
    if (RD_I) begin
      for (int i = 0; i < 2; i++) begin
        if (ADDR_I == reg_addr[i]) begin
          rdata_nxt = {1'b0, on_r[i], 1'b0, per_r[i]};
        end
      end
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // outputs all come straight from flip-flops
  // index 0 feeds timer a and index 1 timer b
  assign RDATA_O = rdata_r;
  assign TMR_A_OUT_O = out_r[0];
  assign TMR_B_OUT_O = out_r[1];
  assign TMR_A_FILT_O = filt_r[0];
  assign TMR_B_FILT_O = filt_r[1];
  assign TMR_A_WAKE_O = wake_r[0];
  assign TMR_B_WAKE_O = wake_r[1];

endmodule
`default_nettype wire

/* cyclic_timer_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// port-level checks of the timer block, bound to its top module
module cyclic_timer_asserts (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic SOFT_RST_I,
  input wire logic RESTART_I,
  input wire logic RESTART_HS_CLR_I,
  input wire logic CYCLIC_SENSE_I,
  input wire logic [6:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [7:0] RDATA_O,
  input wire logic TMR_A_OUT_O,
  input wire logic TMR_B_OUT_O,
  input wire logic TMR_A_FILT_O,
  input wire logic TMR_B_FILT_O,
  input wire logic TMR_A_WAKE_O,
  input wire logic TMR_B_WAKE_O,
  input wire logic TMR_A_WAKE_EN_I,
  input wire logic TMR_B_WAKE_EN_I
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  // any clear source this cycle; a write beside it loses
  logic clr;
  logic wa;
  logic wb;
  assign clr = SOFT_RST_I | RESTART_I | (RESTART_HS_CLR_I & CYCLIC_SENSE_I);
  assign wa = WR_I && ADDR_I == cyclic_timer_pkg::TMR_A_ADDR && !clr;
  assign wb = WR_I && ADDR_I == cyclic_timer_pkg::TMR_B_ADDR && !clr;
  a_rdata_idle: assert property (!RD_I |=> RDATA_O == 8'h00)
    else $error("read data not zero outside a read");
  a_rsvd_zero: assert property (RD_I |=> !RDATA_O[7] && !RDATA_O[3])
    else $error("unused bit read back set");
  a_unmapped_zero: assert property (RD_I && ADDR_I[6:1] != 6'h06
    |=> RDATA_O == 8'h00) else $error("unmapped read not zero");
  a_clear_low: assert property (clr
    |-> ##2 !TMR_A_OUT_O && !TMR_B_OUT_O)
    else $error("output high after clear");
  a_stop_high: assert property (wa && WDATA_I[6:4] == 3'h6
    |-> ##2 TMR_A_OUT_O) else $error("stop-high code not high");
  a_stop_low: assert property (wb && WDATA_I[6:4] == 3'h0
    |-> ##2 !TMR_B_OUT_O) else $error("stop-low code not low");
  a_filt_in_on: assert property (TMR_A_FILT_O |-> TMR_A_OUT_O)
    else $error("filter window outside on-time");
  // the window sits at the end, so the start of on-time is quiet
  a_filt_late: assert property ($rose(TMR_A_OUT_O)
    |-> !TMR_A_FILT_O[*8])
    else $error("filter window at start of on-time");
  a_wake_gated: assert property (TMR_A_WAKE_O |-> TMR_A_FILT_O)
    else $error("wake window without filter window");
  // wake enable is taken at the edge that launches the window
  a_wake_a_follow: assert property (TMR_A_FILT_O
    |-> TMR_A_WAKE_O == $past(TMR_A_WAKE_EN_I))
    else $error("timer a wake window does not follow enable");
  a_filt_b_in_on: assert property (TMR_B_FILT_O |-> TMR_B_OUT_O)
    else $error("timer b filter window outside on-time");
  a_wake_b_gated: assert property (TMR_B_WAKE_O |-> TMR_B_FILT_O)
    else $error("timer b wake window without filter window");
  a_wake_b_follow: assert property (TMR_B_FILT_O
    |-> TMR_B_WAKE_O == $past(TMR_B_WAKE_EN_I))
    else $error("timer b wake window does not follow enable");
  c_filt: cover property ($rose(TMR_A_FILT_O));
  c_wake: cover property (TMR_A_WAKE_O);
  c_clear: cover property (clr);
  c_on_end: cover property ($fell(TMR_A_OUT_O));
endmodule
bind dual_cyclic_sense_timer cyclic_timer_asserts cyclic_timer_asserts_i (
  .CLK_I, .NRST_I, .SOFT_RST_I, .RESTART_I, .RESTART_HS_CLR_I,
  .CYCLIC_SENSE_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O,
  .TMR_A_OUT_O, .TMR_B_OUT_O, .TMR_A_FILT_O, .TMR_B_FILT_O,
  .TMR_A_WAKE_O, .TMR_B_WAKE_O, .TMR_A_WAKE_EN_I, .TMR_B_WAKE_EN_I);
`default_nettype wire

/* hs_partner_model.sv */
`timescale 1ns/1ps
`default_nettype none
// far side: one switch driver and one wake filter in cyclic sensing
module hs_partner_model (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic drive_i,
  input wire logic filt_i,
  input wire logic wake_lvl_i,
  output logic hs_pin_o,
  output logic [7:0] sense_cnt_o
);
  logic filt_r;
  logic filt_nxt;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  // the switch only follows the timer, it adds no delay of its own
  assign hs_pin_o = drive_i;
  assign sense_cnt_o = cnt_r;
  // a wake level is taken when the filter window closes high
  always_comb begin
    filt_nxt = filt_i;
    cnt_nxt = cnt_r;
    if (filt_r && !filt_i && wake_lvl_i) begin
      cnt_nxt = cnt_r + 8'h01;
    end
  end
  // registers only
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      filt_r <= 1'b0;
      cnt_r <= 8'h00;
    end else begin
      filt_r <= filt_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic CLK_I = 0, NRST_I = 0, SOFT_RST_I = 0, RESTART_I = 0;
  logic RESTART_HS_CLR_I = 0, CYCLIC_SENSE_I = 0, WR_I = 0, RD_I = 0;
  logic TMR_A_ASSIGNED_I = 0, TMR_B_ASSIGNED_I = 0, wake_lvl = 0;
  logic TMR_A_WAKE_EN_I = 0, TMR_B_WAKE_EN_I = 0, saw_wake = 0;
  logic [6:0] ADDR_I = 7'h00;
  logic [7:0] WDATA_I = 8'h00, RDATA_O, sense_cnt;
  logic TMR_A_OUT_O, TMR_B_OUT_O, TMR_A_FILT_O, TMR_B_FILT_O;
  logic TMR_A_WAKE_O, TMR_B_WAKE_O, hs_pin;
  int error_cnt = 0, samples_checked = 0;
  localparam logic [6:0] A = 7'h0C, B = 7'h0D;
  // one cycle per tick keeps the 10 ms period at 10000 cycles
  dual_cyclic_sense_timer #(.TICK_CYC(1)) dual_cyclic_sense_timer_i (
    .CLK_I(CLK_I), .NRST_I(NRST_I), .SOFT_RST_I(SOFT_RST_I),
    .RESTART_I(RESTART_I), .RESTART_HS_CLR_I(RESTART_HS_CLR_I),
    .CYCLIC_SENSE_I(CYCLIC_SENSE_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
    .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .TMR_A_ASSIGNED_I(TMR_A_ASSIGNED_I), .TMR_B_ASSIGNED_I(TMR_B_ASSIGNED_I),
    .TMR_A_WAKE_EN_I(TMR_A_WAKE_EN_I), .TMR_B_WAKE_EN_I(TMR_B_WAKE_EN_I),
    .TMR_A_OUT_O(TMR_A_OUT_O), .TMR_B_OUT_O(TMR_B_OUT_O),
    .TMR_A_FILT_O(TMR_A_FILT_O), .TMR_B_FILT_O(TMR_B_FILT_O),
    .TMR_A_WAKE_O(TMR_A_WAKE_O), .TMR_B_WAKE_O(TMR_B_WAKE_O));
  hs_partner_model hs_partner_model_i (.clk_i(CLK_I), .nrst_i(NRST_I),
    .drive_i(TMR_A_OUT_O), .filt_i(TMR_A_FILT_O), .wake_lvl_i(wake_lvl),
    .hs_pin_o(hs_pin), .sense_cnt_o(sense_cnt));
  always #2.5 CLK_I = ~CLK_I;
  always @(posedge CLK_I) if (TMR_A_WAKE_O === 1'b1) saw_wake <= 1'b1;
  task automatic results;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  // durations may run long by the tick alignment, never short
  task automatic cmp_len(input int got, input int exp);
    samples_checked++;
    if (got < exp || got > exp + 2) begin
      error_cnt++;
      $display("Error %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    ADDR_I <= a;
    WDATA_I <= d;
    WR_I <= 1'b1;
    @(posedge CLK_I);
    WR_I <= 1'b0;
    @(posedge CLK_I);
  endtask
  // write that returns at its taking edge, so a timing starts there
  task automatic wr_go(input logic [6:0] a, input logic [7:0] d);
    ADDR_I <= a;
    WDATA_I <= d;
    WR_I <= 1'b1;
    @(posedge CLK_I);
    WR_I <= 1'b0;
  endtask
  // read data are looked at only in the cycle after the strobe
  task automatic chk(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] d;
    ADDR_I <= a;
    RD_I <= 1'b1;
    @(posedge CLK_I);
    RD_I <= 1'b0;
    #1 d = RDATA_O;
    cmp8(d, exp);
    @(posedge CLK_I);
  endtask
  // cycles that an output keeps the given level, bounded
  task automatic meas(input logic b, input logic lvl, output int n);
    n = 0;
    #1;
    while ((b ? TMR_B_OUT_O : TMR_A_OUT_O) === lvl && n < 30000) begin
      @(posedge CLK_I);
      #1;
      n++;
    end
    if (n == 30000) begin
      error_cnt++;
      results;
    end
  endtask
  task automatic t_regs;
    chk(A, 8'h00);
    chk(B, 8'h00);
    wr(A, 8'hFF);
    wr(B, 8'hAA);
    wr(7'h0E, 8'h77);
    chk(A, 8'h77);
    chk(B, 8'h22);
    chk(7'h0E, 8'h00);
  endtask
  task automatic t_stop;
    wr(A, 8'h60);
    cmp8({7'h00, TMR_A_OUT_O}, 8'h01);
    cmp8({7'h00, hs_pin}, 8'h01);
    wr(A, 8'h00);
    cmp8({7'h00, TMR_A_OUT_O}, 8'h00);
    wr(A, 8'h10);
    cmp8({7'h00, TMR_A_OUT_O}, 8'h00);
  endtask
  task automatic t_on;
    int h;
    int l;
    int on_len[4] = '{100, 300, 1000, 10000};
    TMR_A_ASSIGNED_I <= 1'b1;
    TMR_A_WAKE_EN_I <= 1'b1;
    wake_lvl <= 1'b1;
    // a 20 ms period leaves room for the 10 ms on-time to end
    for (int c = 0; c < 4; c++) begin
      wr_go(A, {1'b0, 3'(c + 1), 4'h1});
      meas(1'b0, 1'b1, h);
      cmp_len(h, on_len[c]);
      if (c == 0) begin
        meas(1'b0, 1'b0, l);
        cmp_len(h + l, 20000);
      end
    end
    // the partner counts a closed window one edge after it closes
    @(posedge CLK_I);
    #1;
    cmp8(sense_cnt, 8'h04);
    cmp8({7'h00, saw_wake}, 8'h01);
    TMR_B_ASSIGNED_I <= 1'b1;
    TMR_B_WAKE_EN_I <= 1'b1;
    wr_go(B, 8'h10);
    meas(1'b1, 1'b1, h);
    meas(1'b1, 1'b0, l);
    cmp_len(h, 100);
    cmp_len(h + l, 10000);
    // stop-low code while running pulls the output down at once
    wr(B, 8'h05);
    cmp8({7'h00, TMR_B_OUT_O}, 8'h00);
  endtask
  // soft reset, restart, switch clear with and without cyclic sense
  task automatic t_clear;
    for (int k = 0; k < 4; k++) begin
      wr(A, 8'h35);
      wr(B, 8'h46);
      CYCLIC_SENSE_I <= (k != 3);
      {SOFT_RST_I, RESTART_I, RESTART_HS_CLR_I} <= (k == 3) ? 3'h1 : 3'h4 >> k;
      @(posedge CLK_I);
      {SOFT_RST_I, RESTART_I, RESTART_HS_CLR_I} <= 3'h0;
      @(posedge CLK_I);
      chk(A, (k == 3) ? 8'h35 : 8'h00);
      chk(B, (k == 3) ? 8'h46 : 8'h00);
    end
  endtask
  initial begin
    repeat (4) @(posedge CLK_I);
    NRST_I <= 1'b1;
    @(posedge CLK_I);
    t_regs;
    t_stop;
    t_on;
    t_clear;
    results;
  end
endmodule
`default_nettype wire
